// ===== hw/svp_pkg.sv
// Shared constants and carrier types for the vector and predicate register file
package svp_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned SVP_VL_BITS_DEF = 256;
    localparam int unsigned SVP_VL_BITS_MAX = 2048;
    localparam int unsigned SVP_GRAN_BITS   = 128;
    localparam int unsigned SVP_NUM_VREG    = 32;
    localparam int unsigned SVP_NUM_PREG    = 16;
    localparam int unsigned SVP_NUM_GOV     = 8;
    localparam int unsigned SVP_SCALAR_BITS = 64;
    localparam int unsigned SVP_ELEM_IDX_W  = 8;
    localparam int unsigned SVP_GRAN_W      = 5;
    localparam int unsigned SVP_PRD_IDX_W   = 5;

    // Predicate read index that returns the first-fault register
    localparam logic [4:0]  SVP_PRD_FFAULT  = 5'h10;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        SVP_VREG_RST    = 1'b0;
    localparam logic        SVP_PREG_RST    = 1'b0;
    localparam logic        SVP_FFAULT_RST  = 1'b1;

    // ************************************************************
    // Encodings
    // ************************************************************
    typedef enum logic [2:0] {
        SVP_ES_8   = 3'h0,
        SVP_ES_16  = 3'h1,
        SVP_ES_32  = 3'h2,
        SVP_ES_64  = 3'h3,
        SVP_ES_128 = 3'h4
    } svp_esize_t;

    typedef enum logic [1:0] {
        SVP_WK_VEC    = 2'h0,
        SVP_WK_LEGACY = 2'h1,
        SVP_WK_SCALAR = 2'h2
    } svp_wkind_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic       valid;
        svp_wkind_t kind;
        logic [4:0] dst;
        svp_esize_t esize;
        logic       pred_en;
        logic [2:0] gov;
        logic       zeroing;
    } svp_vwr_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] dst;
        svp_esize_t esize;
        logic       pred_en;
        logic [2:0] gov;
        logic       zeroing;
        logic       permute;
    } svp_pwr_t;

    typedef struct packed {
        logic       valid;
        logic       nonfault;
        svp_esize_t esize;
        logic       pred_en;
        logic [2:0] gov;
        logic       fault;
        logic [7:0] fault_elem;
    } svp_ld_t;

    typedef struct packed {
        logic       valid;
        svp_esize_t esize;
        logic       pred_en;
        logic [2:0] gov;
    } svp_gq_t;

endpackage

// ===== hw/svp_regfile.sv
// Vector, predicate and first-fault register file with predication helpers
// ************************************************************
// How it works
// - Thirty-two vector registers, width a multiple of 128, at most 2048.
// - Elements are 8, 16, 32, 64 or 128 bits, chosen per instruction.
// - Element order effects follow ascending element number.
// - Low 128 bits of each vector register are the legacy register.
// - Legacy write above 128-bit length clears accessible bits above 127.
// - Sixteen predicate registers, one bit per vector byte.
// - Predicate elements are 1, 2, 4, 8 or 16 bits, matching vector elements.
// - A predicate element is true when its lowest bit is one.
// - Non-permute writes store canonical predicates, upper bits zero.
// - Only predicate registers 0 to 7 may govern.
// - Active elements are processed, inactive ones take no part.
// - Inactive destination elements are zeroed or merged.
// - Unpredicated instructions treat all elements as active.
// - First active element is the lowest-numbered true element.
// - Last active element is the highest-numbered true element.
// - First-fault load reports faults only on first active element.
// - Non-fault load suppresses all faults, recording failures.
// - One governing predicate is reinterpreted per element size.
// - First-fault register: init sets all true, failure clears upward.
// - Loads never set first-fault register bits true.
// - Narrow scalar results clear the destination's accessible upper bits.
// ************************************************************
`timescale 1ns/1ns
module svp_regfile #(
    parameter int unsigned VL = svp_pkg::SVP_VL_BITS_DEF  // Vector width in bits
) (
    input  wire logic                   core_clk_i,    // Core clock
    input  wire logic                   rst_i,         // Sync reset, high
    input  wire logic [4:0]             vl_gran_i,     // Current length, 128-bit units
    input  wire svp_pkg::svp_vwr_t      vwr_i,         // Vector write command
    input  wire logic [VL-1:0]          vwr_data_i,    // Vector write data
    input  wire svp_pkg::svp_pwr_t      pwr_i,         // Predicate write command
    input  wire logic [VL/8-1:0]        pwr_data_i,    // Predicate write data
    input  wire logic                   ffault_init_i, // Set first-fault reg all true
    input  wire svp_pkg::svp_ld_t       ld_i,          // Load fault report
    input  wire svp_pkg::svp_gq_t       gq_i,          // Governing predicate query
    input  wire logic [4:0]             vrd_idx_i,     // Vector read index
    input  wire logic [4:0]             prd_idx_i,     // Predicate read index
    output logic [VL-1:0]               vrd_data_o,    // Vector read data
    output logic [127:0]                simd_rd_o,     // Legacy view of read data
    output logic [VL/8-1:0]             prd_data_o,    // Predicate read data
    output logic [VL/8-1:0]             ffault_o,      // First-fault register
    output logic                        any_act_o,     // Query: any element active
    output logic [7:0]                  first_act_o,   // Query: first active element
    output logic [7:0]                  last_act_o,    // Query: last active element
    output logic                        fault_take_o   // Load fault not suppressed
);
    import svp_pkg::*;

    localparam int unsigned NB = VL / 8;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [SVP_NUM_VREG-1:0][VL-1:0] vreg;
        logic [SVP_NUM_PREG-1:0][NB-1:0] preg;
        logic [NB-1:0]                   ffault;
        logic [VL-1:0]                   vrd;
        logic [NB-1:0]                   prd;
        logic                            any;
        logic [7:0]                      first;
        logic [7:0]                      last;
        logic                            ftake;
    } svp_state_t;

    svp_state_t    st_q;
    svp_state_t    st_d;
    logic [NB-1:0] acc;
    logic [NB-1:0] vm;
    logic [NB-1:0] pm;
    logic [NB-1:0] lm;
    logic [NB-1:0] qm;
    logic [NB-1:0] plb;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Byte b is active when the lowest bit of its element is set
    function automatic logic [NB-1:0] act_mask(input logic [NB-1:0] p,
                                               input svp_esize_t es,
                                               input logic pen,
                                               input logic [NB-1:0] a);
        logic [NB-1:0] m;
        int            base;
        m = '0;
        for (int b = 0; b < NB; b++) begin
            base = b - (b % (1 << es));
            m[b] = (pen ? p[base] : 1'b1) & a[b];
        end
        return m;
    endfunction

    // Bits that sit at the lowest position of each element
    function automatic logic [NB-1:0] low_bits(input svp_esize_t es);
        logic [NB-1:0] m;
        m = '0;
        for (int b = 0; b < NB; b++) begin
            m[b] = (b % (1 << es)) == 0;
        end
        return m;
    endfunction

    function automatic logic [VL-1:0] expand(input logic [NB-1:0] m);
        logic [VL-1:0] v;
        v = '0;
        for (int b = 0; b < NB; b++) begin
            v[b*8 +: 8] = {8{m[b]}};
        end
        return v;
    endfunction

    // Ascending scan gives first and last active element numbers
    function automatic logic [17:0] scan(input logic [NB-1:0] m, input svp_esize_t es);
        logic       found;
        logic [7:0] f;
        logic [7:0] l;
        found = 1'b0;
        f = '0;
        l = '0;
        for (int b = 0; b < NB; b++) begin
            if (m[b] && !found) begin
                f = 8'(b >> es);
                found = 1'b1;
            end
            if (m[b]) begin
                l = 8'(b >> es);
            end
        end
        return {found, 1'b0, f, l};
    endfunction

    // Bytes belonging to element number e or higher
    function automatic logic [NB-1:0] from_elem(input logic [7:0] e, input svp_esize_t es);
        logic [NB-1:0] m;
        m = '0;
        for (int b = 0; b < NB; b++) begin
            m[b] = (b >> es) >= int'(e);
        end
        return m;
    endfunction

    function automatic logic [SVP_SCALAR_BITS-1:0] scalar_mask(input svp_esize_t es);
        logic [SVP_SCALAR_BITS-1:0] m;
        m = '0;
        for (int i = 0; i < SVP_SCALAR_BITS; i++) begin
            m[i] = (es >= SVP_ES_64) || (i < (8 << es));
        end
        return m;
    endfunction

    // ************************************************************
    // Accessible bytes under the current vector length
    // ************************************************************
    for (genvar g = 0; g < NB; g++) begin : g_acc
        assign acc[g] = (g / 16) < int'(vl_gran_i);
    end

    // Governing predicate index is three bits wide, so only 0 to 7 govern
    assign vm  = act_mask(st_q.preg[{1'b0, vwr_i.gov}], vwr_i.esize, vwr_i.pred_en, acc);
    assign pm  = act_mask(st_q.preg[{1'b0, pwr_i.gov}], pwr_i.esize, pwr_i.pred_en, acc);
    assign lm  = act_mask(st_q.preg[{1'b0, ld_i.gov}], ld_i.esize, ld_i.pred_en, acc);
    assign qm  = act_mask(st_q.preg[{1'b0, gq_i.gov}], gq_i.esize, gq_i.pred_en, acc);
    assign plb = low_bits(pwr_i.esize);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [VL-1:0] old_v;
        logic [VL-1:0] keep_v;
        logic [NB-1:0] old_p;
        logic [NB-1:0] val_p;
        logic [NB-1:0] keep_p;
        logic [17:0]   sl;
        logic [17:0]   sq;
        st_d = st_q;
        st_d.ftake = 1'b0;
        old_v = st_q.vreg[vwr_i.dst];
        keep_v = '0;
        old_p = st_q.preg[pwr_i.dst];
        val_p = '0;
        keep_p = '0;
        sl = scan(lm, ld_i.esize);
        sq = scan(qm, gq_i.esize);

        if (vwr_i.valid) begin
            case (vwr_i.kind)
                SVP_WK_VEC: begin
                    keep_v = ~expand(vm) & (vwr_i.zeroing ? ~expand(acc) : '1);
                    st_d.vreg[vwr_i.dst] = (vwr_data_i & expand(vm)) | (old_v & keep_v);
                end
                SVP_WK_LEGACY: begin
                    st_d.vreg[vwr_i.dst] = old_v & ~expand(acc);
                    st_d.vreg[vwr_i.dst][127:0] = vwr_data_i[127:0];
                end
                SVP_WK_SCALAR: begin
                    st_d.vreg[vwr_i.dst] = old_v & ~expand(acc);
                    st_d.vreg[vwr_i.dst][SVP_SCALAR_BITS-1:0] =
                        vwr_data_i[SVP_SCALAR_BITS-1:0] & scalar_mask(vwr_i.esize);
                end
                default: begin
                    st_d.vreg[vwr_i.dst] = old_v;
                end
            endcase
        end

        if (pwr_i.valid) begin
            val_p = pwr_i.permute ? pwr_data_i : (pwr_data_i & plb);
            keep_p = ~pm & (pwr_i.zeroing ? ~acc : '1);
            st_d.preg[pwr_i.dst] = (val_p & pm) | (old_p & keep_p);
        end

        if (ffault_init_i) begin
            st_d.ffault = '1;
        end else if (ld_i.valid && ld_i.fault) begin
            if (!ld_i.nonfault && sl[17] && ld_i.fault_elem == sl[15:8]) begin
                st_d.ftake = 1'b1;
            end else begin
                // Clearing only, so the register stays a true run then false
                st_d.ffault = st_q.ffault
                            & ~from_elem(ld_i.fault_elem, ld_i.esize);
            end
        end

        if (gq_i.valid) begin
            st_d.any = sq[17];
            st_d.first = sq[15:8];
            st_d.last = sq[7:0];
        end

        st_d.vrd = st_q.vreg[vrd_idx_i];
        if (prd_idx_i == SVP_PRD_FFAULT) begin
            st_d.prd = st_q.ffault;
        end else begin
            st_d.prd = st_q.preg[prd_idx_i[3:0]];
        end

        if (rst_i) begin
            st_d = '0;
            st_d.vreg = {(SVP_NUM_VREG*VL){SVP_VREG_RST}};
            st_d.preg = {(SVP_NUM_PREG*NB){SVP_PREG_RST}};
            st_d.ffault = {NB{SVP_FFAULT_RST}};
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_q <= st_d;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign vrd_data_o   = st_q.vrd;
    assign simd_rd_o    = st_q.vrd[127:0];
    assign prd_data_o   = st_q.prd;
    assign ffault_o     = st_q.ffault;
    assign any_act_o    = st_q.any;
    assign first_act_o  = st_q.first;
    assign last_act_o   = st_q.last;
    assign fault_take_o = st_q.ftake;

    // ************************************************************
    // Checks
    // ************************************************************
    a_legacy_alias: assert property (@(posedge core_clk_i) disable iff (rst_i)
        vwr_i.valid && vwr_i.kind == SVP_WK_LEGACY |=>
            st_q.vreg[$past(vwr_i.dst)][127:0] == $past(vwr_data_i[127:0]))
        else $error("legacy write not visible in low 128 bits");

    a_legacy_upper: assert property (@(posedge core_clk_i) disable iff (rst_i)
        vwr_i.valid && vwr_i.kind == SVP_WK_LEGACY && vl_gran_i > 5'h01 |=>
            (st_q.vreg[$past(vwr_i.dst)] & expand($past(acc)) & ~{{(VL-128){1'b0}}, {128{1'b1}}})
                == '0)
        else $error("legacy write left upper accessible bits");

    a_zero_inactive: assert property (@(posedge core_clk_i) disable iff (rst_i)
        vwr_i.valid && vwr_i.kind == SVP_WK_VEC && vwr_i.zeroing |=>
            (st_q.vreg[$past(vwr_i.dst)] & expand($past(acc) & ~$past(vm))) == '0)
        else $error("zeroing write kept an inactive element");

    a_pred_canon: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pwr_i.valid && !pwr_i.permute |=>
            (st_q.preg[$past(pwr_i.dst)] & $past(pm) & ~$past(plb)) == '0)
        else $error("predicate write not canonical");

    a_ffault_init: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ffault_init_i |=> st_q.ffault == '1)
        else $error("first-fault init did not set all bits");

    a_ffault_noset: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !ffault_init_i |=> (st_q.ffault & ~$past(st_q.ffault)) == '0)
        else $error("load set a first-fault bit");

    a_nonfault_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ld_i.valid && ld_i.nonfault && !ffault_init_i |=> !fault_take_o)
        else $error("non-fault load raised a fault");

    a_unpred_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        gq_i.valid && !gq_i.pred_en && vl_gran_i != 5'h00 |=>
            any_act_o && first_act_o == 8'h00)
        else $error("unpredicated query not all active");

    a_first_last: assert property (@(posedge core_clk_i) disable iff (rst_i)
        gq_i.valid ##1 any_act_o |-> first_act_o <= last_act_o)
        else $error("first active above last active");

    a_scalar_upper: assert property (@(posedge core_clk_i) disable iff (rst_i)
        vwr_i.valid && vwr_i.kind == SVP_WK_SCALAR |=>
            (st_q.vreg[$past(vwr_i.dst)] & expand($past(acc))
                & ~{{(VL-SVP_SCALAR_BITS){1'b0}}, $past(scalar_mask(vwr_i.esize))}) == '0)
        else $error("scalar write left upper bits");

    a_take_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !(ld_i.valid && ld_i.fault && !ld_i.nonfault) |=> !fault_take_o)
        else $error("fault passed without a first-fault load");

endmodule

// ===== test/svp_pipe_model.sv
// Issue-stage model that drives commands and read indices into the register file
`timescale 1ns/1ns
module svp_pipe_model #(
    parameter int unsigned VL = 256  // Vector width in bits
) (
    input  wire logic      clk_i,   // Core clock
    output logic [4:0]     gran_o,  // Current length, 128-bit units
    output svp_pkg::svp_vwr_t vwr_o,   // Vector write command
    output logic [VL-1:0]  vdat_o,  // Vector write data
    output svp_pkg::svp_pwr_t pwr_o,   // Predicate write command
    output logic [VL/8-1:0] pdat_o, // Predicate write data
    output logic           init_o,  // First-fault init pulse
    output svp_pkg::svp_ld_t  ld_o,    // Load fault report
    output svp_pkg::svp_gq_t  gq_o,    // Governing predicate query
    output logic [4:0]     vidx_o,  // Vector read index
    output logic [4:0]     pidx_o   // Predicate read index
);
    import svp_pkg::*;

    initial begin
        gran_o = 5'h02;
        vwr_o = '0;
        vdat_o = '0;
        pwr_o = '0;
        pdat_o = '0;
        init_o = 1'b0;
        ld_o = '0;
        gq_o = '0;
        vidx_o = 5'h00;
        pidx_o = 5'h00;
    end

    // ************************************************************
    // One command cycle; data lines scrambled once valid drops
    // ************************************************************
    task automatic issue(input svp_vwr_t v, input logic [VL-1:0] vd, input svp_pwr_t p,
                         input logic [VL/8-1:0] pd, input svp_ld_t l, input logic in,
                         input svp_gq_t g);
        @(posedge clk_i);
        vwr_o <= v;
        vdat_o <= vd;
        pwr_o <= p;
        pdat_o <= pd;
        ld_o <= l;
        init_o <= in;
        gq_o <= g;
        @(posedge clk_i);
        vwr_o.valid <= 1'b0;
        pwr_o.valid <= 1'b0;
        ld_o.valid <= 1'b0;
        gq_o.valid <= 1'b0;
        init_o <= 1'b0;
        vdat_o <= ~vd;
        pdat_o <= ~pd;
    endtask

    task automatic rd(input logic [4:0] v, input logic [4:0] p);
        @(posedge clk_i);
        vidx_o <= v;
        pidx_o <= p;
        @(posedge clk_i);
    endtask

    task automatic set_gran(input logic [4:0] g);
        @(posedge clk_i);
        gran_o <= g;
        @(posedge clk_i);
    endtask
endmodule

// ===== test/svp_regfile_bench.sv
// Self-checking bench for the vector and predicate register file
`timescale 1ns/1ns
module svp_regfile_bench;
    import svp_pkg::*;
    localparam int VL = 256;
    localparam int NB = VL / 8;
    typedef enum logic [2:0] {K_VEC, K_SIMD, K_PRD, K_FF, K_TAKE, K_ANY, K_FIRST,
                              K_LAST} svp_kind_t;
    typedef struct {svp_kind_t kind; int due; logic [VL-1:0] exp;} svp_note_t;

    logic            core_clk = 1'b0;
    logic            rst = 1'b1;
    logic [4:0]      gran, vidx, pidx;
    svp_vwr_t        vwr;
    svp_pwr_t        pwr;
    svp_ld_t         ld;
    svp_gq_t         gq;
    logic [VL-1:0]   vdat, vrd;
    logic [NB-1:0]   pdat, prd, ff, ffref;
    logic [127:0]    simd;
    logic            init, any, take;
    logic [7:0]      first, last;
    logic [VL-1:0]   vref [32];
    logic [NB-1:0]   pref [16];
    svp_note_t       notes[$];
    int              cyc = 0;
    int              fails = 0;
    int              check_count = 0;

    always #10 core_clk = ~core_clk;

    svp_pipe_model #(.VL(VL)) pipe_u (.clk_i(core_clk), .gran_o(gran), .vwr_o(vwr),
        .vdat_o(vdat), .pwr_o(pwr), .pdat_o(pdat), .init_o(init), .ld_o(ld), .gq_o(gq),
        .vidx_o(vidx), .pidx_o(pidx));
    svp_regfile #(.VL(VL)) dut_u (.core_clk_i(core_clk), .rst_i(rst), .vl_gran_i(gran),
        .vwr_i(vwr), .vwr_data_i(vdat), .pwr_i(pwr), .pwr_data_i(pdat), .ffault_init_i(init),
        .ld_i(ld), .gq_i(gq), .vrd_idx_i(vidx), .prd_idx_i(pidx), .vrd_data_o(vrd),
        .simd_rd_o(simd), .prd_data_o(prd), .ffault_o(ff), .any_act_o(any),
        .first_act_o(first), .last_act_o(last), .fault_take_o(take));

    // ************************************************************
    // Reference helpers
    // ************************************************************
    function automatic logic [NB-1:0] act(logic pen, logic [2:0] g, logic [2:0] es);
        logic [NB-1:0] m;
        for (int b = 0; b < NB; b++) m[b] = (b < gran * 16) && (!pen || pref[g][(b >> es) << es]);
        return m;
    endfunction

    function automatic logic [16:0] fl(logic pen, logic [2:0] g, logic [2:0] es);
        logic [NB-1:0] m;
        logic [16:0] r;
        m = act(pen, g, es);
        r = '0;
        for (int e = 0; e < (NB >> es); e++) begin
            if (m[e << es]) begin
                if (!r[16]) r[15:8] = 8'(e);
                r[16] = 1'b1;
                r[7:0] = 8'(e);
            end
        end
        return r;
    endfunction

    task automatic note(svp_kind_t k, logic [VL-1:0] e);
        notes.push_back(svp_note_t'{k, cyc + 1, e});
    endtask

    task automatic cmp_data(logic [VL-1:0] got, logic [VL-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(logic [7:0] got, logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ************************************************************
    // Command tasks; rd, lf and gqq note what the outputs must show, vw and pw only update the model
    // ************************************************************
    task automatic rd(logic [4:0] v, logic [4:0] p);
        pipe_u.rd(v, p);
        note(K_VEC, vref[v]);
        note(K_SIMD, VL'(vref[v][127:0]));
        note(K_PRD, VL'((p == 5'h10) ? ffref : pref[p[3:0]]));
        note(K_FF, VL'(ffref));
    endtask

    task automatic vw(svp_wkind_t k, logic [4:0] d, logic [2:0] es, logic pen, logic [2:0] g,
                      logic z);
        svp_vwr_t c;
        logic [VL-1:0] dat, o;
        int w;
        logic [NB-1:0] m;
        for (int i = 0; i < VL / 32; i++) dat[i*32+:32] = $urandom();
        c = '{valid: 1'b1, kind: k, dst: d, esize: svp_esize_t'(es), pred_en: pen, gov: g,
              zeroing: z};
        m = act(pen, g, es);
        o = vref[d];
        w = (k == SVP_WK_LEGACY) ? 16 : (es < 3) ? 1 << es : 8;
        for (int b = 0; b < gran * 16; b++) begin
            if (k != SVP_WK_VEC) o[b*8+:8] = (b < w) ? dat[b*8+:8] : 8'h00;
            else if (m[b]) o[b*8+:8] = dat[b*8+:8];
            else if (pen && z) o[b*8+:8] = 8'h00;
        end
        pipe_u.issue(c, dat, '0, '0, '0, 1'b0, '0);
        vref[d] = o;
    endtask

    task automatic pw(logic [3:0] d, logic [2:0] es, logic pen, logic [2:0] g, logic z,
                      logic perm);
        svp_pwr_t c;
        logic [NB-1:0] dat, o, m;
        dat = $urandom();
        c = '{valid: 1'b1, dst: d, esize: svp_esize_t'(es), pred_en: pen, gov: g, zeroing: z,
              permute: perm};
        m = act(pen, g, es);
        o = pref[d];
        for (int b = 0; b < gran * 16; b++) begin
            if (m[b]) o[b] = dat[b] & (perm || (b % (1 << es) == 0));
            else if (pen && z) o[b] = 1'b0;
        end
        pipe_u.issue('0, '0, c, dat, '0, 1'b0, '0);
        pref[d] = o;
    endtask

    task automatic lf(logic nf, logic [2:0] es, logic pen, logic [2:0] g, logic f,
                      logic [7:0] el, logic in);
        svp_ld_t c;
        logic [16:0] r;
        logic t;
        c = '{valid: 1'b1, nonfault: nf, esize: svp_esize_t'(es), pred_en: pen, gov: g,
              fault: f, fault_elem: el};
        r = fl(pen, g, es);
        t = f && !nf && !in && r[16] && (el == r[15:8]);
        pipe_u.issue('0, '0, '0, '0, c, in, '0);
        note(K_TAKE, VL'(t));
        if (in) ffref = '1;
        else if (f && !t && (int'(el) << es) < NB) ffref &= ~({NB{1'b1}} << (int'(el) << es));
        rd(5'h00, 5'h10);
    endtask

    task automatic gqq(logic [2:0] es, logic pen, logic [2:0] g);
        logic [16:0] r;
        r = fl(pen, g, es);
        pipe_u.issue('0, '0, '0, '0, '0, 1'b0, '{valid: 1'b1, esize: svp_esize_t'(es),
                     pred_en: pen, gov: g});
        note(K_ANY, VL'(r[16]));
        if (r[16]) note(K_FIRST, VL'(r[15:8]));
        if (r[16]) note(K_LAST, VL'(r[7:0]));
    endtask

    task automatic done(string s);
        $display("test %s finished", s);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ************************************************************
    // Watcher: settled outputs against the oldest notes
    // ************************************************************
    always @(negedge core_clk) begin
        svp_note_t n;
        cyc = cyc + 1;
        while (notes.size() > 0 && notes[0].due == cyc) begin
            n = notes.pop_front();
            case (n.kind)
                K_VEC:   cmp_data(vrd, n.exp);
                K_SIMD:  cmp_data(VL'(simd), n.exp);
                K_PRD:   cmp_data(VL'(prd), n.exp);
                K_FF:    cmp_data(VL'(ff), n.exp);
                K_TAKE:  cmp_flag(8'(take), n.exp[7:0]);
                K_ANY:   cmp_flag(8'(any), n.exp[7:0]);
                K_FIRST: cmp_flag(first, n.exp[7:0]);
                default: cmp_flag(last, n.exp[7:0]);
            endcase
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        wrap_up();
    end

    initial begin
        logic [16:0] r;
        for (int i = 0; i < 32; i++) vref[i] = '0;
        for (int i = 0; i < 16; i++) pref[i] = '0;
        ffref = '1;
        void'($urandom(32'h764f1715));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(5'h00, 5'h10);
        done("reset");
        for (int i = 0; i < 32; i++) vw(SVP_WK_VEC, 5'(i), 3'h0, 1'b0, 3'h0, 1'b0);
        for (int i = 0; i < 32; i++) rd(5'(i), 5'h10);
        done("vector");
        for (int i = 0; i < 16; i++) pw(4'(i), 3'(i % 5), 1'b0, 3'h0, 1'b0, i == 8);
        for (int i = 0; i < 16; i++) rd(5'h00, 5'(i));
        rd(5'h00, 5'h11);
        pw(4'hC, 3'h1, 1'b1, 3'h2, 1'b0, 1'b0);
        pw(4'hD, 3'h1, 1'b1, 3'h2, 1'b1, 1'b0);
        rd(5'h00, 5'h0C);
        rd(5'h00, 5'h0D);
        done("predicate");
        for (int es = 0; es < 5; es++) begin
            vw(SVP_WK_VEC, 5'h03, 3'(es), 1'b1, 3'(es + 3), es[0]);
            rd(5'h03, 5'h00);
        end
        done("predicated");
        vw(SVP_WK_LEGACY, 5'h04, 3'h4, 1'b0, 3'h0, 1'b0);
        rd(5'h04, 5'h00);
        pipe_u.set_gran(5'h01);
        vw(SVP_WK_LEGACY, 5'h06, 3'h4, 1'b0, 3'h0, 1'b0);
        rd(5'h06, 5'h00);
        pipe_u.set_gran(5'h02);
        for (int es = 1; es < 5; es += 2) begin
            vw(SVP_WK_SCALAR, 5'h07, 3'(es), 1'b0, 3'h0, 1'b0);
            rd(5'h07, 5'h00);
        end
        done("legacy");
        for (int es = 0; es < 5; es++) begin
            for (int g = 0; g < 8; g++) gqq(3'(es), g != 0, 3'(g));
        end
        done("query");
        lf(1'b0, 3'h2, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1);
        lf(1'b0, 3'h2, 1'b0, 3'h0, 1'b1, 8'h00, 1'b0);
        lf(1'b0, 3'h2, 1'b0, 3'h0, 1'b1, 8'h02, 1'b0);
        lf(1'b1, 3'($urandom() % 3), 1'b0, 3'h0, 1'b1, 8'h01, 1'b0);
        lf(1'b0, 3'($urandom() % 4), 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
        lf(1'b1, 3'h0, 1'b0, 3'h0, 1'b1, 8'h00, 1'b1);
        lf(1'b1, 3'h0, 1'b0, 3'h0, 1'b1, 8'h1F, 1'b0);
        r = fl(1'b1, 3'h1, 3'h1);
        lf(1'b0, 3'h1, 1'b1, 3'h1, 1'b1, r[15:8], 1'b0);
        lf(1'b0, 3'h1, 1'b1, 3'h1, 1'b1, r[15:8] + 8'h01, 1'b0);
        done("fault");
        for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge core_clk);
        if (notes.size() > 0) fails++;
        wrap_up();
    end
endmodule
